// file: logic/seq_ctrl.sv
// Sequencer control register with DMA engine control and DAC output unit
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module seq_ctrl #(
	parameter int NUM_DACS = 4,
	parameter int CNT_W = 16
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic [11:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [11:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read response ready
	input wire logic [CNT_W-1:0] conv_count, // Conversions per block
	input wire logic conv_clk1_tick, // Conversion clock one event
	input wire logic conv_clk2_tick, // Conversion clock two event
	input wire logic frame_trigger, // Frame trigger event
	input wire logic fifo_has_data, // Sequencer FIFO not empty
	output logic fifo_pop, // Take one word from the FIFO
	output logic fifo_flush_request, // Empty the FIFO, one cycle
	output logic [NUM_DACS-1:0] dac_write, // Transfer word into a DAC
	output logic dac_load_pulse_n, // Conversion load pulse, active low
	input wire logic ou_fault, // Output unit error event
	input wire logic dma_xfer_req, // DMA transfer wanted
	input wire logic dma_xfer_done, // Active DMA transfer finished
	input wire logic dma_fault, // DMA bus error event
	output logic dma_xfer_start, // Launch one DMA transfer
	output logic dma_engine_reset // DMA engine held in reset
);
	import seq_ctrl_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		logic aw_got;
		logic w_got;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic start_pend;
		logic fifo_flush;
		ou_state_t ou;
		logic [CNT_W-1:0] remain;
		logic [NUM_DACS-1:0] loaded;
		logic [NUM_DACS-1:0] dac_wr;
		logic [3:0] pulse_cnt;
		dma_state_t dma;
		logic dma_start;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// First DAC still waiting for its pre-load word
	function automatic logic [NUM_DACS-1:0] first_unloaded(input logic [NUM_DACS-1:0] l);
		logic [NUM_DACS-1:0] r;
		r = '0;
		for (int i = NUM_DACS - 1; i >= 0; i--)
		begin
			if (!l[i])
			begin
				r = '0;
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction : first_unloaded

	logic wr_fire;
	logic ctrl_wr;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic ou_en;
	logic dma_en;
	logic ou_rst;
	logic dma_rst;
	logic conv_tick;
	logic all_loaded;
	logic [31:0] status;

	// Byte-lane mask from the write strobes
	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			wmask[b*8 +: 8] = {8{st_ff.wstrb[b]}};
		end
	end

	assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	assign ctrl_wr = wr_fire && (st_ff.awaddr[11:2] == SEQ_CTRL_OFFSET[11:2]);
	assign wval = ctrl_wr ? (st_ff.wdata & wmask) : 32'h0000_0000;
	assign ou_en = st_ff.ctrl[OU_ENA_BIT];
	assign dma_en = st_ff.ctrl[DMA_ENA_BIT];
	assign ou_rst = wval[OU_RST_BIT] || !ou_en;
	assign dma_rst = wval[DMA_RST_BIT];
	assign conv_tick = st_ff.ctrl[CLK_SEL_BIT] ? conv_clk2_tick : conv_clk1_tick;
	assign all_loaded = &st_ff.loaded;

	// Status word showing engine and unit state
	always_comb
	begin
		status = 32'h0000_0000;
		status[ST_DMA_IDLE_BIT] = (st_ff.dma == DMA_IDLE);
		status[ST_DMA_BUSY_BIT] = (st_ff.dma == DMA_BUSY);
		status[ST_DMA_ERR_BIT] = (st_ff.dma == DMA_ERROR);
		status[ST_OU_BUSY_BIT] = (st_ff.ou == OU_RUN) || (st_ff.ou == OU_ARMED);
		status[ST_OU_PRLD_BIT] = all_loaded;
		status[ST_OU_ERR_BIT] = (st_ff.ou == OU_ERROR);
	end

	// Next-state logic for bus, output unit and DMA engine
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.fifo_flush = 1'b0;
		nxt_st.dac_wr = '0;
		nxt_st.dma_start = 1'b0;
		// Write channel: address and data taken in either order
		if (s_axi_awvalid && !st_ff.aw_got)
		begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.w_got)
		begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (wr_fire)
		begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = (st_ff.awaddr[11:2] == SEQ_CTRL_OFFSET[11:2]) ? RESP_OKAY : RESP_SLVERR;
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
		end
		if (st_ff.bvalid && s_axi_bready)
		begin
			nxt_st.bvalid = 1'b0;
		end
		if (ctrl_wr)
		begin
			nxt_st.ctrl = (st_ff.ctrl & ~(wmask & CTRL_RW_MASK)) | (wval & CTRL_RW_MASK);
		end
		// Read channel: one read at a time, unmapped reads give an error
		if (s_axi_arvalid && !st_ff.rvalid)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			if (s_axi_araddr[11:2] == SEQ_CTRL_OFFSET[11:2])
			begin
				nxt_st.rdata = st_ff.ctrl & CTRL_RW_MASK;
			end
			else if (s_axi_araddr[11:2] == SEQ_STAT_OFFSET[11:2])
			begin
				nxt_st.rdata = status;
			end
			else
			begin
				nxt_st.rdata = 32'h0000_0000;
				nxt_st.rresp = RESP_SLVERR;
			end
		end
		else if (st_ff.rvalid && s_axi_rready)
		begin
			nxt_st.rvalid = 1'b0;
		end
		nxt_st.fifo_flush = wval[FIFO_CLR_BIT];
		if (wval[CONV_START_BIT] && ou_en && !st_ff.ctrl[OU_MODE_BIT])
		begin
			nxt_st.start_pend = 1'b1;
		end
		// Load pulse width counter
		if (st_ff.pulse_cnt != 4'd0)
		begin
			nxt_st.pulse_cnt = st_ff.pulse_cnt - 4'd1;
		end
		if (ou_en && st_ff.ou != OU_ERROR && !all_loaded && fifo_has_data && st_ff.dac_wr == '0)
		begin
			nxt_st.dac_wr = first_unloaded(st_ff.loaded);
			nxt_st.loaded = st_ff.loaded | first_unloaded(st_ff.loaded);
		end
		case (st_ff.ou)
			OU_IDLE:
			begin
				if (st_ff.start_pend)
				begin
					nxt_st.start_pend = 1'b0;
					nxt_st.ou = OU_ARMED;
				end
				else if (st_ff.ctrl[OU_MODE_BIT] && frame_trigger)
				begin
					nxt_st.ou = OU_ARMED;
				end
			end
			OU_ARMED:
			begin
				if (conv_tick)
				begin
					nxt_st.remain = conv_count;
					nxt_st.ou = (conv_count == '0) ? OU_IDLE : OU_RUN;
				end
			end
			OU_RUN:
			begin
				if (st_ff.remain == '0)
				begin
					nxt_st.ou = OU_IDLE;
				end
				else if (conv_tick && all_loaded && st_ff.pulse_cnt == 4'd0)
				begin
					nxt_st.pulse_cnt = 4'(LOAD_PULSE_CYC);
					nxt_st.loaded = '0;
					nxt_st.remain = st_ff.remain - 1'b1;
				end
			end
			OU_ERROR:
			begin
				nxt_st.ou = OU_ERROR;
			end
			default:
			begin
				nxt_st.ou = OU_IDLE;
			end
		endcase
		if (ou_fault && ou_en)
		begin
			nxt_st.ou = OU_ERROR;
		end
		if (wval[CLR_PRLD_BIT])
		begin
			nxt_st.loaded = '0;
		end
		if (ou_rst)
		begin
			nxt_st.ou = OU_IDLE;
			nxt_st.remain = '0;
			nxt_st.pulse_cnt = 4'd0;
			nxt_st.start_pend = 1'b0;
			nxt_st.loaded = '0;
			nxt_st.dac_wr = '0;
		end
		// DMA engine, fault wins over completion
		case (st_ff.dma)
			DMA_IDLE:
			begin
				if (dma_en && dma_xfer_req)
				begin
					nxt_st.dma_start = 1'b1;
					nxt_st.dma = DMA_BUSY;
				end
			end
			DMA_BUSY:
			begin
				if (dma_fault)
				begin
					nxt_st.dma = DMA_ERROR;
				end
				else if (dma_xfer_done)
				begin
					nxt_st.dma = DMA_IDLE;
				end
			end
			DMA_ERROR:
			begin
				nxt_st.dma = dma_en ? DMA_ERROR : DMA_IDLE;
			end
			default:
			begin
				nxt_st.dma = DMA_IDLE;
			end
		endcase
		// DMA reset request, idles engine only if no transfer runs in the write cycle
		if (dma_rst && st_ff.dma != DMA_BUSY)
		begin
			nxt_st.dma = DMA_IDLE;
			nxt_st.dma_start = 1'b0;
		end
	end

	// Single register stage for all state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= '0;
			st_ff.ctrl <= CTRL_RESET;
			st_ff.ou <= OU_IDLE;
			st_ff.dma <= DMA_IDLE;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Outputs; awready and wready drop once a channel is taken, arready is low while a read response is pending
	assign s_axi_awready = !st_ff.aw_got;
	assign s_axi_wready = !st_ff.w_got;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = !st_ff.rvalid;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign fifo_flush_request = st_ff.fifo_flush;
	assign dac_write = st_ff.dac_wr;
	assign fifo_pop = |st_ff.dac_wr;
	assign dac_load_pulse_n = (st_ff.pulse_cnt == 4'd0);
	assign dma_xfer_start = st_ff.dma_start;
	// reset held while disabled and not busy
	assign dma_engine_reset = !dma_en && st_ff.dma != DMA_BUSY;

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	ou_disable_reset_a: assert property (!ou_en |=> st_ff.ou == OU_IDLE)
		else $error("output unit not idle while disabled");
	fifo_flush_pulse_a: assert property (ctrl_wr && wval[FIFO_CLR_BIT] |=> fifo_flush_request ##1 !fifo_flush_request)
		else $error("flush pulse wrong");
	ctrl_rsv_zero_a: assert property ((st_ff.ctrl & ~CTRL_RW_MASK) == 32'h0000_0000)
		else $error("self-clearing or reserved bit stored");
	dma_err_hold_a: assert property (st_ff.dma == DMA_ERROR && dma_en && !dma_rst |=> st_ff.dma == DMA_ERROR)
		else $error("DMA left error while enabled");
	dma_busy_finish_a: assert property (st_ff.dma == DMA_BUSY && !dma_xfer_done && !dma_fault |=> st_ff.dma == DMA_BUSY)
		else $error("DMA transfer cut short");
	ou_err_stop_a: assert property (st_ff.ou == OU_ERROR && ou_en |-> dac_load_pulse_n)
		else $error("conversion during output error");
	load_pulse_width_a: assert property ($fell(dac_load_pulse_n) && ou_en |-> !dac_load_pulse_n [*4])
		else $error("load pulse too short");
	preload_stop_a: assert property (all_loaded |=> dac_write == '0)
		else $error("DAC written when fully loaded");
	dma_off_reset_a: assert property (dma_engine_reset |=> !dma_xfer_start)
		else $error("DMA launched while held in reset");
	start_arm_a: assert property (st_ff.start_pend && st_ff.ou == OU_IDLE && !ou_rst && !ou_fault |=> st_ff.ou == OU_ARMED)
		else $error("start did not arm unit");

	normal_start_c: cover property (st_ff.start_pend ##[1:20] !dac_load_pulse_n);
	frame_start_c: cover property (st_ff.ctrl[OU_MODE_BIT] && frame_trigger ##[1:20] st_ff.ou == OU_RUN);
	dma_error_c: cover property (st_ff.dma == DMA_ERROR);
	preload_c: cover property (dac_write != '0);
endmodule : seq_ctrl

// file: logic/seq_ctrl_pkg.sv
// Constants for the sequencer control register bank
package seq_ctrl_pkg;
	localparam logic [11:0] SEQ_CTRL_OFFSET = 12'h02E8;
	localparam logic [11:0] SEQ_STAT_OFFSET = 12'h02EC;
	localparam int OU_ENA_BIT = 0;
	localparam int OU_RST_BIT = 1;
	localparam int OU_MODE_BIT = 2;
	localparam int CONV_START_BIT = 3;
	localparam int CLR_PRLD_BIT = 4;
	localparam int CLK_SEL_BIT = 5;
	localparam int FIFO_CLR_BIT = 8;
	localparam int DMA_ENA_BIT = 16;
	localparam int DMA_RST_BIT = 17;
	// Status layout of the local status word
	localparam int ST_DMA_IDLE_BIT = 16;
	localparam int ST_DMA_BUSY_BIT = 17;
	localparam int ST_DMA_ERR_BIT = 18;
	localparam int ST_OU_BUSY_BIT = 0;
	localparam int ST_OU_PRLD_BIT = 1;
	localparam int ST_OU_ERR_BIT = 2;
	localparam logic [31:0] CTRL_RW_MASK = 32'h0001_0025;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Load pulse width in ns, as cycles at 4 ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int LOAD_PULSE_NS = 20;
	localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		OU_IDLE = 4'b0001,
		OU_ARMED = 4'b0010,
		OU_RUN = 4'b0100,
		OU_ERROR = 4'b1000
	} ou_state_t;
	typedef enum logic [2:0] {
		DMA_IDLE = 3'b001,
		DMA_BUSY = 3'b010,
		DMA_ERROR = 3'b100
	} dma_state_t;
endpackage : seq_ctrl_pkg

// file: bench/dac_far_model.sv
// Far-side model: sequencer FIFO source and quad DAC sink
`timescale 1ns/1ps
module dac_far_model
	import seq_ctrl_pkg::*;
#(
	parameter int NUM_DACS = 4
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic [7:0] fill_words, // Words added this cycle
	input wire logic fifo_pop, // Word taken
	input wire logic fifo_flush_request, // FIFO emptied
	input wire logic [NUM_DACS-1:0] dac_write, // DAC load strobes
	input wire logic dac_load_pulse_n, // Conversion pulse
	output logic fifo_has_data, // FIFO not empty
	output logic [15:0] write_cnt, // DAC words taken
	output logic [15:0] pulse_cnt, // Conversion pulses
	output logic [15:0] flush_cnt, // Flushes seen
	output logic [15:0] fault_cnt // Protocol faults seen
);
	logic [15:0] level;
	logic [7:0] low_len;
	logic bad;
	assign fifo_has_data = (level != 16'h0000);
	// one-hot loads, pop per load, no underflow, fixed pulse width
	assign bad = ($countones(dac_write) > 1) || (fifo_pop !== (|dac_write))
		|| (fifo_pop && level == 16'h0000)
		|| (dac_load_pulse_n && low_len != 8'h00 && low_len != 8'(LOAD_PULSE_CYC));
	// Level and traffic counters; a flush wins over a pop in the same cycle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			level <= 16'h0000;
			low_len <= 8'h00;
			{write_cnt, pulse_cnt, flush_cnt, fault_cnt} <= 64'h0;
		end
		else
		begin
			level <= fifo_flush_request ? 16'h0000 :
				level + {8'h00, fill_words} - {15'h0000, fifo_pop};
			write_cnt <= write_cnt + 16'($countones(dac_write));
			flush_cnt <= flush_cnt + {15'h0000, fifo_flush_request};
			low_len <= dac_load_pulse_n ? 8'h00 : low_len + 8'h01;
			if (dac_load_pulse_n && low_len != 8'h00)
				pulse_cnt <= pulse_cnt + 16'h0001;
			if (bad)
				fault_cnt <= fault_cnt + 16'h0001;
		end
	end
endmodule : dac_far_model

// file: bench/seq_ctrl_tb_top.sv
// Self-checking bench for the sequencer control register bank
`timescale 1ns/1ps
module seq_ctrl_tb_top;
	import seq_ctrl_pkg::*;
	localparam logic [31:0] ENA = 32'h1 << OU_ENA_BIT;
	localparam logic [31:0] ORST = 32'h1 << OU_RST_BIT;
	localparam logic [31:0] MODE = 32'h1 << OU_MODE_BIT;
	localparam logic [31:0] STRT = 32'h1 << CONV_START_BIT;
	localparam logic [31:0] PRLD = 32'h1 << CLR_PRLD_BIT;
	localparam logic [31:0] CLKS = 32'h1 << CLK_SEL_BIT;
	localparam logic [31:0] FCLR = 32'h1 << FIFO_CLR_BIT;
	localparam logic [31:0] DENA = 32'h1 << DMA_ENA_BIT;
	localparam logic [31:0] DRST = 32'h1 << DMA_RST_BIT;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] conv_count = 16'h0003;
	logic conv_clk1_tick = 0, conv_clk2_tick = 0, frame_trigger = 0, ou_fault = 0;
	logic dma_xfer_req = 0, dma_xfer_done = 0, dma_fault = 0;
	logic fifo_has_data, fifo_pop, fifo_flush_request, dac_load_pulse_n;
	logic dma_xfer_start, dma_engine_reset;
	logic [3:0] dac_write;
	logic [7:0] fill_words = 8'h00;
	logic [15:0] write_cnt, pulse_cnt, flush_cnt, fault_cnt, w0, p0, fe;
	logic [31:0] rd, seed;
	logic [1:0] rs;
	logic [1:0] bx = RESP_OKAY;
	int err_count = 0;
	int total_checks = 0;
	int start_cnt = 0;

	seq_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_count,
		.conv_clk1_tick, .conv_clk2_tick, .frame_trigger, .fifo_has_data, .fifo_pop,
		.fifo_flush_request, .dac_write, .dac_load_pulse_n, .ou_fault, .dma_xfer_req,
		.dma_xfer_done, .dma_fault, .dma_xfer_start, .dma_engine_reset);
	dac_far_model far (.aclk, .aresetn, .fill_words, .fifo_pop, .fifo_flush_request,
		.dac_write, .dac_load_pulse_n, .fifo_has_data, .write_cnt, .pulse_cnt,
		.flush_cnt, .fault_cnt);

	// Clock at 4 ns and a count of DMA launches
	always #2 aclk = ~aclk;
	always @(posedge aclk)
		if (dma_xfer_start === 1'b1) start_cnt <= start_cnt + 1;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// Only the stored fields read back; action bits and reserved bits read zero
	function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
		return d & CTRL_RW_MASK;
	endfunction : exp_ctrl

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// Write with both channels offered at once, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", bx, s_axi_bresp);
	endtask : wr
	task automatic rdr(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	// Conversion clock events, spaced so preload and pulse both fit
	task automatic tick(input logic sel, input int n);
		repeat (n)
		begin
			@(posedge aclk);
			{conv_clk2_tick, conv_clk1_tick} <= sel ? 2'b10 : 2'b01;
			@(posedge aclk);
			{conv_clk2_tick, conv_clk1_tick} <= 2'b00;
			cyc(30);
		end
	endtask : tick
	task automatic pulse(input int k);
		@(posedge aclk);
		case (k)
			0: frame_trigger <= 1'b1;
			1: ou_fault <= 1'b1;
			2: dma_fault <= 1'b1;
			default: dma_xfer_done <= 1'b1;
		endcase
		@(posedge aclk);
		{frame_trigger, ou_fault, dma_fault, dma_xfer_done} <= 4'h0;
	endtask : pulse
	task automatic fill(input logic [7:0] n);
		@(posedge aclk);
		fill_words <= n;
		@(posedge aclk);
		fill_words <= 8'h00;
	endtask : fill

	// Hang guard, far beyond the roughly 1300 cycles the tests need
	initial
	begin
		cyc(40000);
		err_count++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		seed = 32'h0000_E4B0;
		fe = 16'h0000;
		cyc(8);
		aresetn <= 1'b1;
		rdr(SEQ_CTRL_OFFSET);
		chk("ctrl reset", CTRL_RESET, rd);
		chk("dma reset", 1, dma_engine_reset);
		chk("load idle", 1, dac_load_pulse_n);
		rdr(12'h100);
		chk("unmapped resp", RESP_SLVERR, rs);
		// Status word is read-only: a write is refused and changes nothing
		bx = RESP_SLVERR;
		wr(SEQ_STAT_OFFSET, 32'hFFFF_FFFF);
		bx = RESP_OKAY;
		rdr(SEQ_CTRL_OFFSET);
		chk("status write ignored", CTRL_RESET, rd);
		repeat (6)
		begin
			seed = xs(seed);
			wr(SEQ_CTRL_OFFSET, seed);
			fe = fe + {15'h0000, seed[FIFO_CLR_BIT]};
			rdr(SEQ_CTRL_OFFSET);
			chk("ctrl rw", exp_ctrl(seed), rd);
		end
		wr(SEQ_CTRL_OFFSET, 32'h0);
		chk("flush count", fe, flush_cnt);
		$display("test registers done");
		fill(8'd100);
		wr(SEQ_CTRL_OFFSET, ENA);
		cyc(20);
		chk("preload", 4, write_cnt);
		tick(1'b0, 2);
		chk("no start", 0, pulse_cnt);
		wr(SEQ_CTRL_OFFSET, ENA | STRT);
		tick(1'b0, 6);
		chk("normal conv", 3, pulse_cnt);
		chk("reload", 16, write_cnt);
		wr(SEQ_CTRL_OFFSET, ENA | CLKS | STRT);
		tick(1'b0, 3);
		chk("clk one idle", 3, pulse_cnt);
		tick(1'b1, 6);
		chk("clk two", 6, pulse_cnt);
		w0 = write_cnt;
		wr(SEQ_CTRL_OFFSET, ENA | PRLD);
		cyc(20);
		chk("prld clear", w0 + 16'd4, write_cnt);
		rdr(SEQ_CTRL_OFFSET);
		chk("self clear", ENA, rd);
		wr(SEQ_CTRL_OFFSET, ENA | MODE);
		p0 = pulse_cnt;
		tick(1'b0, 2);
		chk("frame wait", p0, pulse_cnt);
		// conversion ticks run on the same cycle grid as the trigger
		pulse(0);
		tick(1'b0, 6);
		chk("frame conv", p0 + 16'd3, pulse_cnt);
		wr(SEQ_CTRL_OFFSET, ENA | STRT);
		tick(1'b0, 1);
		pulse(1);
		p0 = pulse_cnt;
		tick(1'b0, 4);
		chk("fault stop", p0, pulse_cnt);
		rdr(SEQ_STAT_OFFSET);
		chk("ou err", 1, rd[ST_OU_ERR_BIT]);
		wr(SEQ_CTRL_OFFSET, ENA | ORST);
		rdr(SEQ_STAT_OFFSET);
		chk("ou rst", 0, rd[ST_OU_ERR_BIT]);
		rdr(SEQ_CTRL_OFFSET);
		chk("regs kept", ENA, rd);
		wr(SEQ_CTRL_OFFSET, 32'h0);
		cyc(4);
		rdr(SEQ_STAT_OFFSET);
		chk("ou off", 0, rd[2:0]);
		wr(SEQ_CTRL_OFFSET, FCLR);
		cyc(2);
		chk("fifo empty", 0, fifo_has_data);
		wr(SEQ_CTRL_OFFSET, ENA);
		w0 = write_cnt;
		cyc(20);
		chk("no data", w0, write_cnt);
		fill(8'd2);
		cyc(20);
		chk("late data", w0 + 16'd2, write_cnt);
		wr(SEQ_CTRL_OFFSET, 32'h0);
		chk("dac protocol", 0, fault_cnt);
		$display("test output unit done");
		wr(SEQ_CTRL_OFFSET, DENA);
		chk("dma run", 0, dma_engine_reset);
		dma_xfer_req <= 1'b1;
		cyc(6);
		chk("one start", 1, start_cnt);
		wr(SEQ_CTRL_OFFSET, 32'h0);
		cyc(4);
		rdr(SEQ_STAT_OFFSET);
		chk("finish first", 1, rd[ST_DMA_BUSY_BIT]);
		pulse(3);
		cyc(4);
		chk("dma held", 1, dma_engine_reset);
		chk("no restart", 1, start_cnt);
		wr(SEQ_CTRL_OFFSET, DENA);
		cyc(4);
		chk("restart", 2, start_cnt);
		pulse(2);
		pulse(3);
		cyc(8);
		chk("halted", 2, start_cnt);
		// Status first, then the engine is reset or disabled
		rdr(SEQ_STAT_OFFSET);
		chk("dma err", 1, rd[ST_DMA_ERR_BIT]);
		dma_xfer_req <= 1'b0;
		wr(SEQ_CTRL_OFFSET, DENA | DRST);
		rdr(SEQ_STAT_OFFSET);
		chk("dma rst", 0, rd[ST_DMA_ERR_BIT]);
		wr(SEQ_CTRL_OFFSET, 32'h0);
		cyc(2);
		chk("dma off", 1, dma_engine_reset);
		$display("test dma done");
		wrap_up();
	end
endmodule : seq_ctrl_tb_top
